// ### design/acr1_top.sv
// Converter control register one with APB slave and current command register.
//
// The APB slave port was chosen for this implementation.
`timescale 1ns/100ps
module acr1_top
  import acr1_pkg::*;
(
  // Clock and reset.
  input  wire logic        REF_CLK,
  input  wire logic        SYS_RST,
  // APB slave.
  input  wire logic        PSEL,
  input  wire logic        PENABLE,
  input  wire logic        PWRITE,
  input  wire logic [11:0] PADDR,
  input  wire logic [31:0] PWDATA,
  output logic [31:0]      PRDATA,
  output logic             PREADY,
  output logic             PSLVERR,
  // Device context.
  input  wire logic        CONV_ENABLE,
  input  wire logic        SPECIAL_MODE,
  input  wire logic        STOP_MODE,
  input  wire logic        WAIT_MODE,
  input  wire logic        STOP_IN_WAIT,
  input  wire logic        CMD_STARTED,
  input  wire logic [31:0] CMD_LOAD_DATA,
  input  wire logic        CMD_LOAD,
  // Outputs to the conversion flow logic.
  output logic             COMMAND_LIST_BUFFER_MODE,
  output logic             RESULT_LIST_BUFFER_MODE,
  output logic             SPECIAL_ACCESS_UNLOCK,
  output logic             AUTO_RESTART_ON_WAKEUP,
  output logic             RESTART_EVENT,
  output logic [31:0]      CURRENT_COMMAND
);
  logic       csl_reg;
  logic       rvl_reg;
  logic       unlock_reg;
  logic       auto_reg;
  logic [31:0] cmd_reg;
  logic       acc;
  logic       wr;
  logic       hit_ctl;
  logic       hit_cmd;
  logic       hit_sts;
  logic       buf_wr_ok;
  logic [7:0] ctl_view;

  // Single-cycle access phase: the slave is always ready.
  assign acc     = PSEL & PENABLE;
  assign wr      = acc & PWRITE;
  assign hit_ctl = (PADDR == ACR1_OFS_CTL_ONE);
  assign hit_cmd = (PADDR == ACR1_OFS_CMD);
  assign hit_sts = (PADDR == ACR1_OFS_STATUS);
  assign PREADY  = 1'b1;
  // Unmapped addresses answer with an error and read zero.
  assign PSLVERR = acc & ~(hit_ctl | hit_cmd | hit_sts);

  // Buffer mode writes are guarded unless the unlock lifts the guard.
  assign buf_wr_ok = ~CONV_ENABLE | unlock_reg;

  // Buffer mode bits.
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
    begin
      csl_reg <= ACR1_CTL_RESET[ACR1_BIT_CSL_MODE];
      rvl_reg <= ACR1_CTL_RESET[ACR1_BIT_RVL_MODE];
    end
    else if (wr && hit_ctl && buf_wr_ok)
    begin
      csl_reg <= PWDATA[ACR1_BIT_CSL_MODE];
      rvl_reg <= PWDATA[ACR1_BIT_RVL_MODE];
    end
  end

  // Unlock bit; leaving special mode clears it and wins over a write.
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      unlock_reg <= ACR1_CTL_RESET[ACR1_BIT_UNLOCK];
    else if (!SPECIAL_MODE)
      unlock_reg <= 1'b0;
    else if (wr && hit_ctl)
      unlock_reg <= PWDATA[ACR1_BIT_UNLOCK];
  end

  // Auto restart bit has no write guard at all.
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      auto_reg <= ACR1_CTL_RESET[ACR1_BIT_AUTO_RST];
    else if (wr && hit_ctl)
      auto_reg <= PWDATA[ACR1_BIT_AUTO_RST];
  end

  // Current command: the flow logic loads it; the bus may patch it only
  // while unlocked and before conversion starts. A load from the flow
  // logic wins, since losing a fetched command would stall the list.
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      cmd_reg <= ACR1_CMD_RESET;
    else if (CMD_LOAD)
      cmd_reg <= CMD_LOAD_DATA;
    else if (wr && hit_cmd && unlock_reg && !CMD_STARTED)
      cmd_reg <= PWDATA;
  end

  // Read view; low nibble is always zero.
  always_comb
  begin
    ctl_view = ACR1_CTL_RESET;
    ctl_view[ACR1_BIT_CSL_MODE] = csl_reg;
    ctl_view[ACR1_BIT_RVL_MODE] = rvl_reg;
    ctl_view[ACR1_BIT_UNLOCK]   = unlock_reg;
    ctl_view[ACR1_BIT_AUTO_RST] = auto_reg;
    ctl_view = ctl_view & ACR1_CTL_MASK;
  end

  // Registered read data, updated during the setup phase of a read.
  always_ff @(posedge REF_CLK or posedge SYS_RST)
  begin
    if (SYS_RST)
      PRDATA <= 32'h00000000;
    else if (PSEL && !PENABLE && !PWRITE)
    begin
      if (hit_ctl)
        PRDATA <= {24'h000000, ctl_view};
      else if (hit_cmd)
        PRDATA <= cmd_reg;
      else if (hit_sts)
        PRDATA <= {29'h00000000, CMD_STARTED, SPECIAL_MODE, CONV_ENABLE};
      else
        PRDATA <= 32'h00000000;
    end
  end

  // Restart event generator.
  acr1_wake u_wake (
    .clk                    (REF_CLK),
    .rst                    (SYS_RST),
    .stop_mode              (STOP_MODE),
    .wait_mode              (WAIT_MODE),
    .stop_in_wait           (STOP_IN_WAIT),
    .auto_restart_on_wakeup (auto_reg),
    .restart_pulse          (RESTART_EVENT)
  );

  assign COMMAND_LIST_BUFFER_MODE = csl_reg;
  assign RESULT_LIST_BUFFER_MODE  = rvl_reg;
  assign SPECIAL_ACCESS_UNLOCK    = unlock_reg;
  assign AUTO_RESTART_ON_WAKEUP   = auto_reg;
  assign CURRENT_COMMAND          = cmd_reg;
endmodule

// ### design/acr1_pkg.sv
// Package with constants for the converter control register one block.
// Function
// - Bit 7 selects command list single (0) or double (1) buffering.
// - Buffer mode bits write only when converter disabled or special unlock set.
// - Bit 6 selects result list single (0) or double (1) buffering.
// - Special unlock bit 5 writable only in special operating mode.
// - Special unlock clears automatically when special mode is left.
// - Unlock set lifts per-bit write restrictions; clear keeps them.
// - Unlock set makes current command writable until its conversion starts.
// - Bit 4 set makes a restart event after stop or wait-with-stop exit.
// - Auto restart bit writable anytime.
package acr1_pkg;
  localparam logic [11:0] ACR1_OFS_CTL_ONE   = 12'h004;
  localparam logic [11:0] ACR1_OFS_CMD       = 12'h008;
  localparam logic [11:0] ACR1_OFS_STATUS    = 12'h00C;
  localparam int          ACR1_BIT_CSL_MODE  = 7;
  localparam int          ACR1_BIT_RVL_MODE  = 6;
  localparam int          ACR1_BIT_UNLOCK    = 5;
  localparam int          ACR1_BIT_AUTO_RST  = 4;
  localparam logic [7:0]  ACR1_CTL_RESET     = 8'h00;
  localparam logic [7:0]  ACR1_CTL_MASK      = 8'hF0;
  localparam int          ACR1_CMD_W         = 32;
  localparam logic [31:0] ACR1_CMD_RESET     = 32'h00000000;
  typedef enum logic [1:0] {
    ACR1_RUN     = 2'h0,
    ACR1_STOPPED = 2'h1,
    ACR1_WAKE    = 2'h3
  } acr1_pwr_t;
endpackage

// ### design/acr1_wake.sv
// Wakeup tracker that produces the automatic restart pulse.
`timescale 1ns/100ps
module acr1_wake
  import acr1_pkg::*;
(
  // Clock and reset.
  input  wire logic clk,
  input  wire logic rst,
  // Power state and control.
  input  wire logic stop_mode,
  input  wire logic wait_mode,
  input  wire logic stop_in_wait,
  input  wire logic auto_restart_on_wakeup,
  // Event out.
  output logic      restart_pulse
);
  acr1_pwr_t state_reg;
  acr1_pwr_t state_next;
  logic      asleep;

  // Wait counts as sleep only when the stop-in-wait option is on.
  assign asleep = stop_mode | (wait_mode & stop_in_wait);

  // Track entry and exit of a low power phase.
  always_comb
  begin
    state_next = state_reg;
    case (state_reg)
      ACR1_RUN:     if (asleep) state_next = ACR1_STOPPED;
      ACR1_STOPPED: if (!asleep) state_next = ACR1_WAKE;
      ACR1_WAKE:    state_next = asleep ? ACR1_STOPPED : ACR1_RUN;
      default:      state_next = ACR1_RUN;
    endcase
  end

  // State register.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      state_reg <= ACR1_RUN;
    else
      state_reg <= state_next;
  end

  // Pulse one cycle after exit, sampling the bit while in the wake state.
  always_ff @(posedge clk or posedge rst)
  begin
    if (rst)
      restart_pulse <= 1'b0;
    else
      restart_pulse <= (state_reg == ACR1_WAKE) & auto_restart_on_wakeup;
  end
endmodule

// ### tb/acr1_props.sv
// Checker with concurrent assertions for converter control register one.
`timescale 1ns/100ps
module acr1_props
  import acr1_pkg::*;
(
  // Clock, reset and bus.
  input wire logic        REF_CLK, SYS_RST, PSEL, PENABLE, PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA, CURRENT_COMMAND,
  // Device context and controls.
  input wire logic        CONV_ENABLE, SPECIAL_MODE, STOP_MODE, WAIT_MODE, STOP_IN_WAIT,
  input wire logic        CMD_STARTED, CMD_LOAD, COMMAND_LIST_BUFFER_MODE,
  input wire logic        RESULT_LIST_BUFFER_MODE, SPECIAL_ACCESS_UNLOCK,
  input wire logic        AUTO_RESTART_ON_WAKEUP, RESTART_EVENT
);
  logic wc, gate, wm, asleep;
  // Write strobes; a mode write lands only when the guard is open.
  assign wc = PSEL & PENABLE & PWRITE & (PADDR == ACR1_OFS_CTL_ONE);
  assign gate = wc & (!CONV_ENABLE | SPECIAL_ACCESS_UNLOCK);
  assign wm = PSEL & PENABLE & PWRITE & (PADDR == ACR1_OFS_CMD) & !CMD_LOAD;
  assign asleep = STOP_MODE | (WAIT_MODE & STOP_IN_WAIT);
  default clocking @(posedge REF_CLK); endclocking
  default disable iff (SYS_RST);
  // Power state leaves sleep.
  sequence wake_exit;
    asleep ##1 !asleep;
  endsequence
  a_csl_write: assert property (gate |=> COMMAND_LIST_BUFFER_MODE == $past(PWDATA[7]))
    else $error("command list mode wrong");
  a_rvl_write: assert property (gate |=> RESULT_LIST_BUFFER_MODE == $past(PWDATA[6]))
    else $error("result list mode wrong");
  a_mode_hold: assert property (!gate |=> $stable(COMMAND_LIST_BUFFER_MODE) &&
    $stable(RESULT_LIST_BUFFER_MODE)) else $error("guarded mode changed");
  a_unlock_set: assert property ($rose(SPECIAL_ACCESS_UNLOCK) |-> $past(wc & SPECIAL_MODE))
    else $error("unlock set outside special mode");
  a_unlock_drop: assert property (!SPECIAL_MODE |=> !SPECIAL_ACCESS_UNLOCK)
    else $error("unlock kept");
  a_auto_write: assert property (wc |=> AUTO_RESTART_ON_WAKEUP == $past(PWDATA[4]))
    else $error("auto restart bit wrong");
  a_restart_due: assert property (wake_exit ##1 AUTO_RESTART_ON_WAKEUP |=> RESTART_EVENT)
    else $error("restart missing");
  a_restart_one: assert property (RESTART_EVENT |-> $past(AUTO_RESTART_ON_WAKEUP)
    ##1 !RESTART_EVENT) else $error("bad restart pulse");
  a_cmd_write: assert property (wm && SPECIAL_ACCESS_UNLOCK && !CMD_STARTED
    |=> CURRENT_COMMAND == $past(PWDATA)) else $error("command not written");
endmodule
bind acr1_top acr1_props i_acr1_props (.*);

// ### tb/acr1_top_tb.sv
// Self-checking bench for converter control register one.
`timescale 1ns/100ps
module acr1_top_tb;
  import acr1_pkg::*;
  logic        REF_CLK = 1'h0, SYS_RST = 1'h1, PSEL = 1'h0, PENABLE = 1'h0, PWRITE = 1'h0;
  logic        CONV_ENABLE = 1'h0, SPECIAL_MODE = 1'h0, STOP_MODE = 1'h0, WAIT_MODE = 1'h0;
  logic        STOP_IN_WAIT = 1'h0, CMD_STARTED = 1'h0, CMD_LOAD = 1'h0, PREADY, PSLVERR, err;
  logic        COMMAND_LIST_BUFFER_MODE, RESULT_LIST_BUFFER_MODE, SPECIAL_ACCESS_UNLOCK;
  logic        AUTO_RESTART_ON_WAKEUP, RESTART_EVENT;
  logic [11:0] PADDR = 12'h000;
  logic [31:0] PWDATA = 32'h0, CMD_LOAD_DATA = 32'h0, PRDATA, CURRENT_COMMAND, rd;
  int          err_total = 0, check_count = 0;
  // Clock at 100 MHz; t_misc drives one command load that races a bus write.
  always #5 REF_CLK = ~REF_CLK;
  acr1_top i_acr1_top (.*);
  // Compare a seen value with the expected one.
  task automatic chk(input string nm, input logic [31:0] s, e);
    check_count++;
    if (s !== e)
    begin
      $display("[FAIL] %s expected %h seen %h", nm, e, s);
      err_total++;
    end
  endtask
  // One bus transfer; an idle edge follows so strobes never change twice at once.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    n = 0;
    PSEL <= 1'h1;
    PWRITE <= w;
    PADDR <= a;
    PWDATA <= d;
    @(posedge REF_CLK);
    PENABLE <= 1'h1;
    do @(posedge REF_CLK); while (PREADY !== 1'b1 && ++n < 20);
    if (n == 20) err_total++;
    rd = PRDATA;
    err = PSLVERR;
    PSEL <= 1'h0;
    PENABLE <= 1'h0;
    @(posedge REF_CLK);
  endtask
  // Register scenario: reset value, guards, unlock and command access.
  task automatic t_regs();
    xfer(1'b0, ACR1_OFS_CTL_ONE, 32'h0);
    chk("ctl reset", rd, 32'h0);
    xfer(1'b0, 12'h010, 32'h0);
    chk("unmapped", {31'h0, err}, 32'h1);
    xfer(1'b1, ACR1_OFS_CTL_ONE, 32'hFF);
    xfer(1'b0, ACR1_OFS_CTL_ONE, 32'h0);
    chk("ctl free", rd, 32'hD0);
    CONV_ENABLE <= 1'h1;
    xfer(1'b1, ACR1_OFS_CTL_ONE, 32'h00);
    xfer(1'b0, ACR1_OFS_CTL_ONE, 32'h0);
    chk("ctl guarded", rd, 32'hC0);
    SPECIAL_MODE <= 1'h1;
    xfer(1'b1, ACR1_OFS_CTL_ONE, 32'h20);
    xfer(1'b1, ACR1_OFS_CTL_ONE, 32'h30);
    xfer(1'b0, ACR1_OFS_CTL_ONE, 32'h0);
    chk("ctl unlocked", rd, 32'h30);
    xfer(1'b1, ACR1_OFS_CMD, 32'h12345678);
    CMD_STARTED <= 1'h1;
    xfer(1'b1, ACR1_OFS_CMD, 32'hA5A5A5A5);
    xfer(1'b0, ACR1_OFS_CMD, 32'h0);
    chk("cmd", rd, 32'h12345678);
    SPECIAL_MODE <= 1'h0;
    CMD_STARTED <= 1'h0;
    xfer(1'b1, ACR1_OFS_CTL_ONE, 32'hE0);
    xfer(1'b1, ACR1_OFS_CMD, 32'h0);
    chk("cmd locked", CURRENT_COMMAND, 32'h12345678);
    xfer(1'b0, ACR1_OFS_CTL_ONE, 32'h0);
    chk("ctl relocked", rd, 32'h00);
    CONV_ENABLE <= 1'h0;
    $display("register test done");
  endtask
  // Sleep then wake, and count restart pulses.
  task automatic t_wake(input logic s, w, i, a, input int e);
    int n;
    n = 0;
    xfer(1'b1, ACR1_OFS_CTL_ONE, {27'h0, a, 4'h0});
    STOP_MODE <= s;
    WAIT_MODE <= w;
    STOP_IN_WAIT <= i;
    repeat (3) @(posedge REF_CLK);
    STOP_MODE <= 1'h0;
    WAIT_MODE <= 1'h0;
    repeat (6)
    begin
      // Look at the pulse mid-cycle, where it has settled.
      @(negedge REF_CLK);
      n += int'(RESTART_EVENT === 1'b1);
    end
    chk("restart", n, e);
    $display("wake test done");
  endtask
  // Control outputs, status view, unlock drop and a flow load racing a bus write.
  task automatic t_misc();
    xfer(1'b1, ACR1_OFS_CTL_ONE, 32'hC0);
    chk("csl out", COMMAND_LIST_BUFFER_MODE, 32'h1);
    chk("rvl out", RESULT_LIST_BUFFER_MODE, 32'h1);
    CONV_ENABLE <= 1'h1;
    SPECIAL_MODE <= 1'h1;
    CMD_STARTED <= 1'h1;
    xfer(1'b0, ACR1_OFS_STATUS, 32'h0);
    chk("status", rd, 32'h7);
    xfer(1'b1, ACR1_OFS_CTL_ONE, 32'h20);
    chk("unlock out", SPECIAL_ACCESS_UNLOCK, 32'h1);
    CMD_STARTED <= 1'h0;
    CMD_LOAD <= 1'h1;
    CMD_LOAD_DATA <= 32'h0BADF00D;
    xfer(1'b1, ACR1_OFS_CMD, 32'h11111111);
    CMD_LOAD <= 1'h0;
    chk("cmd load", CURRENT_COMMAND, 32'h0BADF00D);
    SPECIAL_MODE <= 1'h0;
    CONV_ENABLE <= 1'h0;
    @(posedge REF_CLK);
    @(negedge REF_CLK);
    chk("unlock drop", SPECIAL_ACCESS_UNLOCK, 32'h0);
    $display("misc test done");
  endtask
  // Report the counts and the verdict, then stop.
  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  // Main sequence after a two-cycle reset.
  initial
  begin
    repeat (2) @(posedge REF_CLK);
    SYS_RST <= 1'h0;
    @(posedge REF_CLK);
    t_regs();
    t_misc();
    t_wake(1'b1, 1'b0, 1'b0, 1'b1, 1);
    t_wake(1'b0, 1'b1, 1'b1, 1'b1, 1);
    t_wake(1'b0, 1'b1, 1'b0, 1'b1, 0);
    t_wake(1'b1, 1'b0, 1'b0, 1'b0, 0);
    close_out();
  end
  // Watchdog at 2000 cycles, well beyond the hundred or so cycles the tests need.
  initial
  begin
    #20000;
    err_total++;
    close_out();
  end
endmodule
